// ### rtl/ledf_params.svh
`ifndef LEDF_PARAMS_SVH
`define LEDF_PARAMS_SVH
`define LEDF_CLK_HZ 40000000
`define LEDF_CLK_NS 25
`define LEDF_DEB_MS 37
`define LEDF_DEB_MIN_MS 25
`define LEDF_DEB_MAX_MS 50
`define LEDF_DEB_CYC ((`LEDF_DEB_MS * `LEDF_CLK_HZ) / 1000)
`define LEDF_TICK_US 1000
`define LEDF_TICK_CYC ((`LEDF_TICK_US * (`LEDF_CLK_HZ / 1000000)))
`define LEDF_SW_LAT_NS 6000
`define LEDF_SW_LAT_CYC (`LEDF_SW_LAT_NS / `LEDF_CLK_NS)
`define LEDF_STEPS 63
`define LEDF_STEP_W 6
`define LEDF_DUTY_W 10
`define LEDF_FADE_W 12
`define LEDF_DEB_CNT_W 24
`define LEDF_TICK_CNT_W 20
`define LEDF_NCH 2
`endif

// ### rtl/ledf_pkg.sv
`include "ledf_params.svh"
package ledf_pkg;
   typedef logic [`LEDF_STEP_W-1:0] ledf_step_t;
   typedef logic [`LEDF_DUTY_W-1:0] ledf_duty_t;
   typedef enum logic [1:0] {
      CH_OFF,
      CH_RAMP_UP,
      CH_ON,
      CH_RAMP_DOWN
   } ledf_chan_e;
   typedef struct packed {
      logic level;
      logic rise;
      logic fall;
   } ledf_deb_s;
   typedef struct packed {
      ledf_chan_e st;
      ledf_step_t step;
      logic latch;
   } ledf_chan_s;
endpackage

// ### rtl/ledf_debounce.sv
`timescale 1ns/1ps
`include "ledf_params.svh"
module ledf_debounce
   import ledf_pkg::*;
#(
   parameter int DEB_CYC = `LEDF_DEB_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clear,
   input wire logic din,
   output ledf_deb_s deb
);
   logic prime;
   logic [`LEDF_DEB_CNT_W-1:0] cnt;
   logic next_prime;
   logic [`LEDF_DEB_CNT_W-1:0] next_cnt;
   ledf_deb_s next_deb;

   // First sample after reset only primes the filter, never an edge
   always_comb begin
      next_prime = prime;
      next_cnt = cnt;
      next_deb = '{level: deb.level, rise: 1'b0, fall: 1'b0};
      if (clear) begin
         next_prime = 1'b0;
         next_cnt = '0;
      end else if (!prime) begin
         next_prime = 1'b1;
         next_deb.level = din;
      end else if (din == deb.level) begin
         next_cnt = '0;
      end else if (cnt == `LEDF_DEB_CNT_W'(DEB_CYC - 1)) begin
         next_cnt = '0;
         next_deb.level = din;
         next_deb.rise = din;
         next_deb.fall = !din;
      end else begin
         next_cnt = cnt + `LEDF_DEB_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prime <= 1'b0;
         cnt <= '0;
         deb <= '0;
      end else begin
         prime <= next_prime;
         cnt <= next_cnt;
         deb <= next_deb;
      end
   end

   a_bounce_ignored: assert property (@(posedge clk) disable iff (!rstn)
      prime && !clear && din != $past(din) |=> !deb.rise && !deb.fall)
      else $error("debounce passed an unqualified edge");
endmodule

// ### rtl/ledf_gamma_rom.sv
`timescale 1ns/1ps
`include "ledf_params.svh"
module ledf_gamma_rom
   import ledf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire ledf_step_t addr_a,
   input wire ledf_step_t addr_b,
   output ledf_duty_t data_a,
   output ledf_duty_t data_b
);
   localparam ledf_duty_t TABLE [64] = '{
      10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00a, 10'h00c, 10'h010,
      10'h014, 10'h018, 10'h01c, 10'h020, 10'h024, 10'h02a, 10'h030, 10'h036,
      10'h03c, 10'h042, 10'h048, 10'h050, 10'h058, 10'h060, 10'h068, 10'h070,
      10'h07a, 10'h084, 10'h090, 10'h09c, 10'h0a8, 10'h0b6, 10'h0c4, 10'h0d2,
      10'h0e2, 10'h0f2, 10'h102, 10'h114, 10'h126, 10'h13a, 10'h14e, 10'h162,
      10'h178, 10'h18e, 10'h1a6, 10'h1be, 10'h1d6, 10'h1f0, 10'h20a, 10'h226,
      10'h242, 10'h260, 10'h27e, 10'h29e, 10'h2be, 10'h2e0, 10'h302, 10'h326,
      10'h34a, 10'h370, 10'h394, 10'h3b6, 10'h3d4, 10'h3ec, 10'h3f8, 10'h3ff
   };

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_a <= '0;
         data_b <= '0;
      end else begin
         data_a <= TABLE[addr_a];
         data_b <= TABLE[addr_b];
      end
   end
endmodule

// ### rtl/ledf_top.sv
// Function
// - Each main channel has its own independent enable input.
// - Main fades with a nonzero fade time step through 63 gamma-corrected brightness steps; a zero fade time jumps straight to the end step.
// - A new toggle mid-fade reverses direction from the present step.
// - Strap high selects pulse mode, strap low selects level mode.
// - Pulse mode: qualified low pulse toggles latch, ramp up or down.
// - Level mode: qualified high ramps an off channel up, on stays on.
// - Level mode: qualified low ramps an on channel down, off stays off.
// - Both main channels start off after power-up regardless of inputs.
// - Main enable inputs are debounced so bounce gives one transition only.
// - Rising and falling edges get the same debounce qualification.
// - Third channel follows its enable directly, no fade, no latch.
// - Third channel turns on within about 6 us of enable high.
// - Third channel stays off while its enable is low.
// - Pulse-width signal on third enable dims it by duty cycle.
// - Main fades start from the shared fade input or an enable toggle.
// - Debounce time lies between 25 and 50 ms, typically 37 ms.
// - Loss of retention supply clears channel latches to off.
`timescale 1ns/1ps
`include "ledf_params.svh"
module ledf_top
   import ledf_pkg::*;
#(
   parameter int DEB_CYC = `LEDF_DEB_CYC,
   parameter int TICK_CYC = `LEDF_TICK_CYC,
   parameter int FADE_W = `LEDF_FADE_W
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [`LEDF_NCH-1:0] MAIN_CHANNEL_ENABLE_INPUTS,
   input wire logic ENABLE_BEHAVIOUR_STRAP,
   input wire logic SHARED_FADE_INPUT,
   input wire logic SHARED_FADE_SELECT,
   input wire logic [FADE_W-1:0] FADE_UP_TIME_SET,
   input wire logic [FADE_W-1:0] FADE_DOWN_TIME_SET,
   input wire logic SUPPLY_LOST,
   input wire logic SWITCH_LIGHT_ENABLE_INPUT,
   output logic [`LEDF_NCH-1:0] MAIN_CURRENT_OUTPUTS,
   output logic [`LEDF_NCH-1:0] MAIN_CHANNEL_ON,
   output logic [`LEDF_NCH-1:0] MAIN_RAMPING,
   output logic SWITCH_LIGHT_OUTPUT
);
   localparam int SW_LAT = `LEDF_SW_LAT_CYC;
   localparam int NCH = `LEDF_NCH;
   localparam ledf_step_t TOP_STEP = `LEDF_STEP_W'(`LEDF_STEPS);

   function automatic ledf_step_t ledf_advance(ledf_step_t s, logic up);
      ledf_step_t r;
      r = up ? s + `LEDF_STEP_W'(1) : s - `LEDF_STEP_W'(1);
      return r;
   endfunction

   function automatic ledf_chan_e ledf_status(ledf_step_t s, logic latch);
      ledf_chan_e r;
      if (latch)
         r = (s == TOP_STEP) ? CH_ON : CH_RAMP_UP;
      else
         r = (s == '0) ? CH_OFF : CH_RAMP_DOWN;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Strap, debounce and step tick

   logic strap;
   logic alive;
   ledf_deb_s deb [NCH+1];
   logic [NCH:0] deb_in;
   logic [`LEDF_TICK_CNT_W-1:0] tick_cnt;
   logic [`LEDF_TICK_CNT_W-1:0] next_tick_cnt;
   logic tick;
   logic next_tick;

   // Strap is static, so plain sampling after release is enough
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         strap <= 1'b0;
         alive <= 1'b0;
      end else begin
         strap <= ENABLE_BEHAVIOUR_STRAP;
         alive <= 1'b1;
      end
   end

   assign deb_in = {SHARED_FADE_INPUT, MAIN_CHANNEL_ENABLE_INPUTS};

   for (genvar g = 0; g <= NCH; g++) begin : g_deb
      ledf_debounce #(
         .DEB_CYC(DEB_CYC)
      ) u_deb (
         .clk(CLOCK),
         .rstn(RSTN),
         .clear(SUPPLY_LOST),
         .din(deb_in[g]),
         .deb(deb[g])
      );
   end

   always_comb begin
      next_tick = 1'b0;
      next_tick_cnt = tick_cnt + `LEDF_TICK_CNT_W'(1);
      if (tick_cnt == `LEDF_TICK_CNT_W'(TICK_CYC - 1)) begin
         next_tick_cnt = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel latch and fade ramp

   ledf_chan_s ch [NCH];
   ledf_chan_s next_ch [NCH];
   logic [FADE_W:0] acc [NCH];
   logic [FADE_W:0] next_acc [NCH];
   logic [FADE_W:0] sum;
   logic [FADE_W:0] span;

   // Accumulating 63 per tick against the fade time gives exactly 63
   // steps per fade; fade times of 1 to 62 ms saturate at one step a tick
   always_comb begin
      sum = '0;
      span = '0;
      for (int i = 0; i < NCH; i++) begin
         next_ch[i] = ch[i];
         next_acc[i] = acc[i];
         if (strap) begin
            if (deb[i].fall)
               next_ch[i].latch = !ch[i].latch;
         end else if (deb[i].rise) begin
            next_ch[i].latch = 1'b1;
         end else if (deb[i].fall) begin
            next_ch[i].latch = 1'b0;
         end
         if (SHARED_FADE_SELECT && deb[NCH].rise)
            next_ch[i].latch = 1'b1;
         if (SHARED_FADE_SELECT && deb[NCH].fall)
            next_ch[i].latch = 1'b0;
         if (next_ch[i].latch != ch[i].latch)
            next_acc[i] = '0;
         span = {1'b0, next_ch[i].latch ? FADE_UP_TIME_SET
                                        : FADE_DOWN_TIME_SET};
         if (ledf_status(ch[i].step, next_ch[i].latch) inside
             {CH_RAMP_UP, CH_RAMP_DOWN}) begin
            if (span == '0) begin
               next_ch[i].step = next_ch[i].latch ? TOP_STEP : '0;
            end else if (tick) begin
               sum = next_acc[i] + (FADE_W+1)'(`LEDF_STEPS);
               if (sum >= span) begin
                  next_ch[i].step = ledf_advance(ch[i].step,
                                                 next_ch[i].latch);
                  next_acc[i] = sum - span;
                  if (next_acc[i] >= span)
                     next_acc[i] = '0;
               end else begin
                  next_acc[i] = sum;
               end
            end
         end else begin
            next_acc[i] = '0;
         end
         if (SUPPLY_LOST) begin
            next_ch[i].latch = 1'b0;
            next_ch[i].step = '0;
            next_acc[i] = '0;
         end
         next_ch[i].st = ledf_status(next_ch[i].step, next_ch[i].latch);
      end
   end

   for (genvar g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge CLOCK or negedge RSTN) begin
         if (!RSTN) begin
            ch[g] <= '{st: CH_OFF, step: '0, latch: 1'b0};
            acc[g] <= '0;
         end else begin
            ch[g] <= next_ch[g];
            acc[g] <= next_acc[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Gamma lookup and output modulation

   ledf_duty_t duty [NCH];
   ledf_duty_t pwm_cnt;
   ledf_duty_t next_pwm_cnt;
   logic [NCH-1:0] next_out;
   logic [NCH-1:0] next_on;
   logic [NCH-1:0] next_ramp;
   logic next_sw;

   ledf_gamma_rom u_rom (
      .clk(CLOCK),
      .rstn(RSTN),
      .addr_a(ch[0].step),
      .addr_b(ch[1].step),
      .data_a(duty[0]),
      .data_b(duty[1])
   );

   // Top step is forced fully on since the table peak stays one count short
   always_comb begin
      next_pwm_cnt = pwm_cnt + `LEDF_DUTY_W'(1);
      for (int i = 0; i < NCH; i++) begin
         next_out[i] = (ch[i].step == TOP_STEP) ||
                       (ch[i].step != '0 && pwm_cnt < duty[i]);
         next_on[i] = ch[i].latch;
         next_ramp[i] = ch[i].st inside {CH_RAMP_UP, CH_RAMP_DOWN};
      end
      next_sw = SWITCH_LIGHT_ENABLE_INPUT;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pwm_cnt <= '0;
         MAIN_CURRENT_OUTPUTS <= '0;
         MAIN_CHANNEL_ON <= '0;
         MAIN_RAMPING <= '0;
         SWITCH_LIGHT_OUTPUT <= 1'b0;
      end else begin
         pwm_cnt <= next_pwm_cnt;
         MAIN_CURRENT_OUTPUTS <= next_out;
         MAIN_CHANNEL_ON <= next_on;
         MAIN_RAMPING <= next_ramp;
         SWITCH_LIGHT_OUTPUT <= next_sw;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   logic quiet0;
   assign quiet0 = !SUPPLY_LOST &&
                   !(SHARED_FADE_SELECT && (deb[NCH].rise || deb[NCH].fall));

   a_powerup_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !alive |-> ch[0].latch == 1'b0 && ch[1].latch == 1'b0 &&
                 ch[0].step == '0 && ch[1].step == '0)
      else $error("channel not off after reset");

   a_pulse_toggle: assert property (@(posedge CLOCK) disable iff (!RSTN)
      strap && deb[0].fall && quiet0 |=> ch[0].latch != $past(ch[0].latch))
      else $error("pulse mode did not toggle latch");

   a_level_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !strap && deb[0].rise && quiet0 |=> ch[0].latch)
      else $error("level high did not switch channel on");

   a_level_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !strap && deb[0].fall && quiet0 |=> !ch[0].latch)
      else $error("level low did not switch channel off");

   a_step_single: assert property (@(posedge CLOCK) disable iff (!RSTN)
      FADE_UP_TIME_SET != '0 && FADE_DOWN_TIME_SET != '0 && !SUPPLY_LOST
      |=> ch[0].step <= TOP_STEP &&
          (ch[0].step == $past(ch[0].step) ||
           ch[0].step == $past(ch[0].step) + `LEDF_STEP_W'(1) ||
           ch[0].step == $past(ch[0].step) - `LEDF_STEP_W'(1)))
      else $error("fade step jumped");

   a_reverse_keep: assert property (@(posedge CLOCK) disable iff (!RSTN)
      ch[0].st == CH_RAMP_UP && !next_ch[0].latch && !SUPPLY_LOST &&
      FADE_DOWN_TIME_SET != '0
      |=> ch[0].step == $past(ch[0].step) ||
          ch[0].step == $past(ch[0].step) - `LEDF_STEP_W'(1))
      else $error("interrupted ramp restarted");

   a_step_timer: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !tick && !SUPPLY_LOST && FADE_UP_TIME_SET != '0 &&
      FADE_DOWN_TIME_SET != '0 && next_ch[0].latch == ch[0].latch
      |=> ch[0].step == $past(ch[0].step))
      else $error("step moved without timer tick");

   a_sw_latency: assert property (@(posedge CLOCK) disable iff (!RSTN)
      $rose(SWITCH_LIGHT_ENABLE_INPUT) ##1 SWITCH_LIGHT_ENABLE_INPUT
      |-> ##[0:SW_LAT] SWITCH_LIGHT_OUTPUT)
      else $error("switch light slow to turn on");

   a_sw_off: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !SWITCH_LIGHT_ENABLE_INPUT |=> !SWITCH_LIGHT_OUTPUT)
      else $error("switch light on with enable low");

   a_supply_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
      SUPPLY_LOST |=> !ch[0].latch && !ch[1].latch && ch[0].step == '0 &&
                      ch[1].step == '0 ##1 MAIN_CHANNEL_ON == '0)
      else $error("supply loss did not clear latches");

   a_full_on: assert property (@(posedge CLOCK) disable iff (!RSTN)
      ch[1].step == TOP_STEP |=> MAIN_CURRENT_OUTPUTS[1])
      else $error("full step not fully on");

   c_pulse_fade: cover property (@(posedge CLOCK) disable iff (!RSTN)
      strap && deb[0].fall ##1 ch[0].st == CH_RAMP_UP);

   c_interrupt: cover property (@(posedge CLOCK) disable iff (!RSTN)
      ch[0].st == CH_RAMP_UP ##1 ch[0].st == CH_RAMP_DOWN);

   c_level_off: cover property (@(posedge CLOCK) disable iff (!RSTN)
      !strap && ch[1].st == CH_ON ##1 ch[1].st == CH_RAMP_DOWN);

   c_shared: cover property (@(posedge CLOCK) disable iff (!RSTN)
      SHARED_FADE_SELECT && deb[NCH].rise ##1 MAIN_RAMPING == 2'h3);
endmodule

// ### verif/ledf_switch_model.sv
`timescale 1ns/1ps
module ledf_switch_model #(
   parameter int DEB_CYC = 12
) (
   input wire logic clk,
   output logic [1:0] en,
   output logic sw_light
);
   // Lines start released: pulled up in pulse mode, light input pulled low
   initial begin
      en = 2'h3;
      sw_light = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Contact bounce: glitches back to the old level, each far shorter
   // than the debounce time, then the new level is held for hold cycles
   task automatic drive(input int ch, input logic lvl, input int hold);
      int g;
      for (int i = 0; i < 3; i++) begin
         g = 1 + $urandom_range(DEB_CYC / 3);
         repeat (g) @(posedge clk) en[ch] <= lvl;
         @(posedge clk) en[ch] <= ~lvl;
      end
      repeat (hold) @(posedge clk) en[ch] <= lvl;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Outside dimming of the switch light; zero and full duty are legal
   task automatic pwm(input int period, input int high, input int n);
      repeat (n) begin
         for (int i = 0; i < period; i++)
            @(posedge clk) sw_light <= (i < high);
      end
      @(posedge clk) sw_light <= 1'b0;
   endtask
endmodule

// ### verif/led_enable_debounce_fade_ctrl_tb_top.sv
`timescale 1ns/1ps
module led_enable_debounce_fade_ctrl_tb_top;
   localparam int DEB = 12;
   localparam int TICK = 4;
   localparam int TUP = 63;
   localparam int TDN = 126;
   logic clk, rstn, strap, sfi, sfs, slost, sl_chk, sl_prev;
   logic [11:0] fup, fdn;
   logic [1:0] en, cur, on, ramp;
   logic sw, slo;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   int sl_hi = 0;
   int u, d, t0, h0, per, hi;

   ledf_switch_model #(.DEB_CYC(DEB)) sw_m (.clk(clk), .en(en),
      .sw_light(sw));

   ledf_top #(.DEB_CYC(DEB), .TICK_CYC(TICK)) u_dut (
      .CLOCK(clk), .RSTN(rstn), .MAIN_CHANNEL_ENABLE_INPUTS(en),
      .ENABLE_BEHAVIOUR_STRAP(strap), .SHARED_FADE_INPUT(sfi),
      .SHARED_FADE_SELECT(sfs), .FADE_UP_TIME_SET(fup),
      .FADE_DOWN_TIME_SET(fdn), .SUPPLY_LOST(slost),
      .SWITCH_LIGHT_ENABLE_INPUT(sw), .MAIN_CURRENT_OUTPUTS(cur),
      .MAIN_CHANNEL_ON(on), .MAIN_RAMPING(ramp),
      .SWITCH_LIGHT_OUTPUT(slo));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (miscompares == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_on(input int ch, input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (on[ch] !== v && n < 60);
   endtask

   task automatic ramp_len(input int ch, output int len);
      int n;
      n = 0;
      len = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ramp[ch] !== 1'b1 && n < 40);
      while (ramp[ch] === 1'b1 && len < 2000) begin
         @(negedge clk);
         len++;
      end
   endtask

   // Output must hold one level once the ROM lag has passed
   task automatic steady(input int ch, input logic v, input string what);
      int bad;
      bad = 0;
      repeat (4) @(negedge clk);
      repeat (40) begin
         @(negedge clk);
         if (cur[ch] !== v) bad++;
      end
      check(what, 16'(bad), 16'h0000);
   endtask

   function automatic logic in_rng(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction

   // Light output shows the input seen one edge earlier
   always @(negedge clk) begin
      if (sl_chk) check("switch_light", 16'(slo), 16'(sl_prev));
      sl_prev = sw;
      if (slo === 1'b1) sl_hi++;
   end

   ////////////////////////////////////////////////////////////////////////
   // Whole sequence needs well under 20000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      void'($urandom(32'h3b26164b));
      rstn = 1'b0;
      strap = 1'b0;
      sfi = 1'b0;
      sfs = 1'b0;
      slost = 1'b0;
      sl_chk = 1'b0;
      sl_prev = 1'b0;
      fup = 12'(TUP);
      fdn = 12'(TDN);
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // High enables in level mode at power-up must not turn channels on
      repeat (3 * DEB) @(negedge clk);
      check("power_up_on", 16'(on), 16'h0000);
      @(posedge clk) strap <= 1'b1;
      sl_chk = 1'b1;
      // Pulse mode: one bouncy press turns ch0 on over the up time
      sw_m.drive(0, 1'b0, DEB + 1 + $urandom_range(6));
      wait_on(0, 1'b1);
      check("press_on", 16'(on), 16'h0001);
      ramp_len(0, u);
      check("up_len", 16'(in_rng(u, 61 * TICK, 64 * TICK + 4)), 16'h1);
      steady(0, 1'b1, "full_on");
      sw_m.drive(0, 1'b1, DEB + 2);
      // A wrongly taken rise would reach the port two edges later
      repeat (4) @(negedge clk);
      check("release_on", 16'(on), 16'h0001);
      // Presses shorter than the debounce time leave no trace
      sw_m.drive(0, 1'b0, DEB - 4);
      sw_m.drive(0, 1'b1, DEB + 2);
      check("short_on", 16'({on, ramp}), 16'h0004);
      // Reversal of ch1 mid-ramp: down starts from the present step
      sw_m.drive(1, 1'b0, DEB + 1);
      wait_on(1, 1'b1);
      t0 = cyc;
      repeat (60 + $urandom_range(40)) @(negedge clk);
      sw_m.drive(1, 1'b1, DEB + 2);
      sw_m.drive(1, 1'b0, DEB + 1);
      wait_on(1, 1'b0);
      u = cyc - t0;
      ramp_len(1, d);
      check("rev_len", 16'(in_rng(d, 2 * u - 24, 2 * u + 24)), 16'h1);
      check("rev_on", 16'(on), 16'h0001);
      steady(1, 1'b0, "rev_off");
      sw_m.drive(1, 1'b1, DEB + 2);
      // Second press on ch0 ramps it down over the down time
      sw_m.drive(0, 1'b0, DEB + 1);
      wait_on(0, 1'b0);
      ramp_len(0, d);
      check("dn_len", 16'(in_rng(d, 124*TICK, 127*TICK+4)), 16'h1);
      steady(0, 1'b0, "full_off");
      sw_m.drive(0, 1'b1, DEB + 2);
      // Level mode: fall when off and a short high change nothing
      @(posedge clk) strap <= 1'b0;
      sw_m.drive(0, 1'b0, DEB + 1);
      sw_m.drive(0, 1'b1, DEB - 4);
      sw_m.drive(0, 1'b0, DEB + 1);
      repeat (4) @(negedge clk);
      check("lvl_off", 16'(on), 16'h0000);
      sw_m.drive(0, 1'b1, DEB + 1);
      wait_on(0, 1'b1);
      sw_m.drive(1, 1'b0, DEB + 1);
      sw_m.drive(1, 1'b1, DEB + 1);
      wait_on(1, 1'b1);
      check("lvl_on", 16'(on), 16'h0003);
      sw_m.drive(0, 1'b0, DEB + 1);
      wait_on(0, 1'b0);
      check("lvl_fall", 16'(on), 16'h0002);
      // Retention loss clears latches; still-high enable is not an edge
      @(posedge clk) slost <= 1'b1;
      repeat (3) @(posedge clk);
      slost <= 1'b0;
      repeat (2 * DEB) @(negedge clk);
      check("lost_on", 16'(on), 16'h0000);
      // Shared fade input with instant fade times drives both channels
      @(posedge clk) begin
         sfs <= 1'b1;
         sfi <= 1'b1;
         fup <= 12'h000;
         fdn <= 12'h000;
      end
      wait_on(1, 1'b1);
      check("shared_on", 16'(on), 16'h0003);
      steady(1, 1'b1, "shared_cur_on");
      @(posedge clk) sfi <= 1'b0;
      wait_on(0, 1'b0);
      check("shared_off", 16'(on), 16'h0000);
      steady(0, 1'b0, "shared_cur_off");
      // Switch light dimmed by duty, including zero and full duty
      for (int r = 0; r < 16; r++) begin
         per = 20 + $urandom_range(40);
         hi = (r == 0) ? 0 : (r == 1) ? per : $urandom_range(per);
         h0 = sl_hi;
         sw_m.pwm(per, hi, 3);
         repeat (2) @(negedge clk);
         check("light_duty", 16'(sl_hi - h0), 16'(3 * hi));
      end
      summarize();
   end
endmodule
